// ---- include/mscb_pkg.sv ----
// Purpose: Constants and types for the mode 1 and mode 2 settings bank
// Assumes: 10 MHz clock, byte-wide register port behind the serial target
// Notes:   Bank words sit at consecutive byte addresses from the base
package mscb_pkg;
   localparam logic [7:0] BANK_BASE     = 8'h27;
   localparam int         BANK_WORDS    = 7;
   localparam logic [7:0] ADDR_M1_BTN   = 8'h27;
   localparam logic [7:0] ADDR_M1_RAILS = 8'h28;
   localparam logic [7:0] ADDR_M1_WDOG  = 8'h29;
   localparam logic [7:0] ADDR_M2_SHIP  = 8'h2a;
   localparam logic [7:0] ADDR_M2_BTN   = 8'h2b;
   localparam logic [7:0] ADDR_M2_RAILS = 8'h2c;
   localparam logic [7:0] ADDR_M2_WDOG  = 8'h2d;
   localparam logic [7:0] ADDR_RST_MON  = 8'h71;
   localparam int         WD_FLAG_BIT   = 1;

   // Reset values in bank order, base address first
   localparam logic [7:0] RST_BANK [BANK_WORDS] = '{8'h4c, 8'h4f, 8'h0c, 8'h1c, 8'h4c, 8'h4f, 8'h0c};

   localparam logic [1:0] MODE_ZERO = 2'h0;
   localparam logic [1:0] MODE_ONE  = 2'h1;
   localparam logic [1:0] MODE_TWO  = 2'h2;
   localparam logic [1:0] WD_OFF    = 2'h0;

   localparam longint CLK_HZ         = 64'd10_000_000;
   localparam longint WD_BASE_S      = 64'd16;
   localparam longint WD_BASE_CYCLES = WD_BASE_S * CLK_HZ;

   // Voltage code mapping, millivolts
   localparam logic [11:0] MV_STEP        = 12'd25;
   localparam logic [11:0] CORE_BASE_MV   = 12'd500;
   localparam logic [11:0] CORE_TOP_MV    = 12'd1500;
   localparam logic [11:0] CORE_FIXED_MV  = 12'd1800;
   localparam logic [5:0]  CORE_TOP_CODE  = 6'h28;
   localparam logic [5:0]  CORE_FIXED     = 6'h3f;
   localparam logic [11:0] SYS_BASE_MV    = 12'd1500;
   localparam logic [11:0] SYS_TOP_MV     = 12'd2100;
   localparam logic [4:0]  SYS_TOP_CODE   = 5'h18;
   localparam logic [11:0] OFFSET_MV      = 12'd1200;
   localparam logic [11:0] AO_BASE_MV     = 12'd1700;
   localparam logic [11:0] AO_TOP_MV      = 12'd1900;
   localparam logic [3:0]  AO_TOP_CODE    = 4'h8;

   // One mode's settings, four bytes, part 0 in the top byte
   typedef struct packed {
      logic       ship;
      logic       pin_select;
      logic [5:0] core_buck_code;
      logic       rsvd;
      logic       button_stay;
      logic       system_buck_offset;
      logic [4:0] system_buck_code;
      logic [3:0] always_on_code;
      logic       core_buck_on;
      logic       system_buck_on;
      logic       always_on_on;
      logic       system_linear_on;
      logic [1:0] watchdog_period;
      logic       system_linear_offset;
      logic [4:0] system_linear_code;
   } mscb_cfg_t;

   typedef struct packed {
      logic [11:0] core_buck;
      logic [11:0] system_buck;
      logic [11:0] always_on;
      logic [11:0] system_linear;
   } mscb_mv_t;
endpackage

// ---- logic/mscb_bank.sv ----
// Purpose: Mode 1 and mode 2 settings bank, mode tracking and watchdog
// Assumes: Power button pin already debounced; pins are asynchronous
// Notes:   Mode 0 and 3 settings and mode 1 part 0 arrive from other banks
`timescale 1ns/1ps

// How it works
// (R01) Button fall with action 0 returns mode 0
// (R02) Button fall with action 1 keeps mode
// (R03) System buck adds 1.2 V when offset set
// (R04) System buck code 1.5-2.1 V, saturating
// (R05) Always-on code 1.7-1.9 V, saturating
// (R06) Four rail enables per mode
// (R07) Watchdog field: off, 16, 32, 64 s
// (R08) System linear adds 1.2 V when offset set
// (R09) System linear code maps like system buck
// (R10) Active ship bit drives ship mode
// (R11) Pin select 0: register bits choose mode
// (R12) Pin select 1: pins choose mode
// (R13) Core buck 0.5-1.5 V, top code 1.8 V
// (R14) Watchdog expiry resets, sets write-1-clear flag
// (R15) Only active mode copy drives outputs
// (R16) All bank bits read/write, reset to defaults
module mscb_bank #(
   parameter longint WD_CYCLES = mscb_pkg::WD_BASE_CYCLES
) (
   input  wire logic              clock,
   input  wire logic              rst_n,
   input  wire logic              reg_wr,
   input  wire logic              reg_rd,
   input  wire logic [7:0]        reg_addr,
   input  wire logic [7:0]        reg_wdata,
   output logic      [7:0]        reg_rdata,
   input  wire logic [7:0]        mode1_part0,
   input  wire mscb_pkg::mscb_cfg_t outer_cfg,
   input  wire logic              mode_pin_a,
   input  wire logic              mode_pin_b,
   input  wire logic              mode_reg_bit_a,
   input  wire logic              mode_reg_bit_b,
   input  wire logic              power_button,
   input  wire logic              wd_kick,
   output logic      [1:0]        active_mode,
   output mscb_pkg::mscb_cfg_t    active_cfg,
   output mscb_pkg::mscb_mv_t     rail_mv,
   output logic                   ship_mode,
   output logic                   sys_reset,
   output logic                   watchdog_reset_flag
);
   // Refused at elaboration: the 32-bit counter must hold four base periods
   if (WD_CYCLES < 1 || WD_CYCLES * 4 > 64'hffff_ffff) begin : g_bad_wd
      $error("WD_CYCLES out of range");
   end

   localparam logic [31:0] WD_PERIOD = 32'(WD_CYCLES);

   logic [7:0]          bank_q [mscb_pkg::BANK_WORDS];
   logic [7:0]          bank_d [mscb_pkg::BANK_WORDS];
   logic [7:0]          rdata_q, rdata_d;
   logic [2:0]          sync1_q, sync2_q;
   logic                btn_prev_q;
   logic [1:0]          mode_q, mode_d, req, req_prev_q;
   logic [31:0]         wd_cnt_q, wd_cnt_d, wd_limit;
   logic [1:0]          wd_sel_q;
   logic                fire_q, fire_d, flag_q, flag_d;
   logic                in_bank, fall, flag_clear;
   logic [7:0]          idx;
   mscb_pkg::mscb_cfg_t cfg1, cfg2, act, act_q;
   mscb_pkg::mscb_mv_t  mv_d, mv_q;

   function automatic logic [11:0] core_mv(input logic [5:0] c);
      if (c == mscb_pkg::CORE_FIXED) core_mv = mscb_pkg::CORE_FIXED_MV;
      else if (c > mscb_pkg::CORE_TOP_CODE) core_mv = mscb_pkg::CORE_TOP_MV;
      else core_mv = 12'(mscb_pkg::CORE_BASE_MV + {6'h00, c} * mscb_pkg::MV_STEP);
   endfunction

   // Shared by system buck and system linear
   function automatic logic [11:0] sys_mv(input logic [4:0] c, input logic off);
      logic [11:0] base;
      base = (c > mscb_pkg::SYS_TOP_CODE) ? mscb_pkg::SYS_TOP_MV
           : 12'(mscb_pkg::SYS_BASE_MV + {7'h00, c} * mscb_pkg::MV_STEP);
      sys_mv = off ? 12'(base + mscb_pkg::OFFSET_MV) : base;
   endfunction

   function automatic logic [11:0] ao_mv(input logic [3:0] c);
      ao_mv = (c > mscb_pkg::AO_TOP_CODE) ? mscb_pkg::AO_TOP_MV
            : 12'(mscb_pkg::AO_BASE_MV + {8'h00, c} * mscb_pkg::MV_STEP);
   endfunction

   // Register port
   assign idx        = reg_addr - mscb_pkg::BANK_BASE;
   assign in_bank    = (reg_addr >= mscb_pkg::BANK_BASE) && (idx < 8'(mscb_pkg::BANK_WORDS));
   assign flag_clear = reg_wr && (reg_addr == mscb_pkg::ADDR_RST_MON) && reg_wdata[mscb_pkg::WD_FLAG_BIT];

   always_comb begin
      for (int i = 0; i < mscb_pkg::BANK_WORDS; i++) begin
         bank_d[i] = bank_q[i];
      end
      if (reg_wr && in_bank) begin
         bank_d[idx[2:0]] = reg_wdata; // R16
      end
      rdata_d = rdata_q;
      if (reg_rd) begin
         rdata_d = 8'h00;
         if (in_bank) begin
            rdata_d = bank_q[idx[2:0]]; // R16
         end else if (reg_addr == mscb_pkg::ADDR_RST_MON) begin
            rdata_d[mscb_pkg::WD_FLAG_BIT] = flag_q;
         end
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         for (int i = 0; i < mscb_pkg::BANK_WORDS; i++) begin
            bank_q[i] <= mscb_pkg::RST_BANK[i]; // R16
         end
         rdata_q <= 8'h00;
      end else begin
         bank_q  <= bank_d;
         rdata_q <= rdata_d;
      end
   end

   assign reg_rdata = rdata_q;

   // Active copy selection; other modes stored but idle
   assign cfg1 = mscb_pkg::mscb_cfg_t'({mode1_part0, bank_q[0], bank_q[1], bank_q[2]});
   assign cfg2 = mscb_pkg::mscb_cfg_t'({bank_q[3], bank_q[4], bank_q[5], bank_q[6]});

   always_comb begin
      case (mode_q)
         mscb_pkg::MODE_ONE: act = cfg1; // R15
         mscb_pkg::MODE_TWO: act = cfg2; // R15
         default:            act = outer_cfg;
      endcase
   end

   // Pins and button pass two flops before use
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         sync1_q    <= 3'h4;
         sync2_q    <= 3'h4;
         btn_prev_q <= 1'b1;
      end else begin
         sync1_q    <= {power_button, mode_pin_b, mode_pin_a};
         sync2_q    <= sync1_q;
         btn_prev_q <= sync2_q[2];
      end
   end

   assign fall = btn_prev_q & ~sync2_q[2];
   assign req  = act.pin_select ? sync2_q[1:0] // R12
                                : {mode_reg_bit_b, mode_reg_bit_a}; // R11

   // Only a change of the request moves the mode, so a button return sticks
   always_comb begin
      mode_d = mode_q;
      if (req != req_prev_q) begin
         mode_d = req;
      end
      if (fall && !act.button_stay) begin
         mode_d = mscb_pkg::MODE_ZERO; // R01
      end
   end // R02

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         mode_q     <= mscb_pkg::MODE_ZERO;
         req_prev_q <= mscb_pkg::MODE_ZERO;
      end else begin
         mode_q     <= mode_d;
         req_prev_q <= req;
      end
   end

   // Watchdog; expiry leaves the bank untouched
   always_comb begin
      unique case (act.watchdog_period)
         2'h1:    wd_limit = WD_PERIOD; // R07
         2'h2:    wd_limit = WD_PERIOD << 1;
         2'h3:    wd_limit = WD_PERIOD << 2;
         default: wd_limit = 32'h0000_0000;
      endcase
      fire_d   = 1'b0;
      wd_cnt_d = wd_cnt_q + 32'h0000_0001;
      if (act.watchdog_period == mscb_pkg::WD_OFF || wd_kick || act.watchdog_period != wd_sel_q) begin
         wd_cnt_d = 32'h0000_0000;
      end else if (wd_cnt_q >= wd_limit - 32'h0000_0001) begin
         wd_cnt_d = 32'h0000_0000;
         fire_d   = 1'b1; // R14
      end
      flag_d = flag_q;
      if (flag_clear) begin
         flag_d = 1'b0;
      end
      if (fire_q) begin
         flag_d = 1'b1; // R14
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         wd_cnt_q <= 32'h0000_0000;
         wd_sel_q <= mscb_pkg::WD_OFF;
         fire_q   <= 1'b0;
         flag_q   <= 1'b0;
      end else begin
         wd_cnt_q <= wd_cnt_d;
         wd_sel_q <= act.watchdog_period;
         fire_q   <= fire_d;
         flag_q   <= flag_d;
      end
   end

   // Registered outputs cost a cycle but keep the analog side glitch free
   always_comb begin
      mv_d.core_buck     = core_mv(act.core_buck_code); // R13
      mv_d.system_buck   = sys_mv(act.system_buck_code, act.system_buck_offset); // R03 R04
      mv_d.always_on     = ao_mv(act.always_on_code); // R05
      mv_d.system_linear = sys_mv(act.system_linear_code, act.system_linear_offset); // R08 R09
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         mv_q  <= '0;
         act_q <= '0;
      end else begin
         mv_q  <= mv_d;
         act_q <= act; // R06 R10
      end
   end

   assign active_mode         = mode_q;
   assign active_cfg          = act_q;
   assign rail_mv             = mv_q;
   assign ship_mode           = act_q.ship; // R10
   assign sys_reset           = fire_q;
   assign watchdog_reset_flag = flag_q;

   property p_btn_zero;
      @(posedge clock) disable iff (!rst_n) fall && !act.button_stay |=> mode_q == mscb_pkg::MODE_ZERO;
   endproperty
   a_btn_zero: assert property (p_btn_zero) else $error("button did not return mode 0"); // R01

   property p_btn_stay;
      @(posedge clock) disable iff (!rst_n) fall && act.button_stay && req == req_prev_q |=> $stable(mode_q);
   endproperty
   a_btn_stay: assert property (p_btn_stay) else $error("button moved mode"); // R02

   property p_sys_sat;
      @(posedge clock) disable iff (!rst_n) act.system_buck_code > mscb_pkg::SYS_TOP_CODE
         |=> rail_mv.system_buck == ($past(act.system_buck_offset) ? 12'd3300 : 12'd2100);
   endproperty
   a_sys_sat: assert property (p_sys_sat) else $error("system buck saturation wrong"); // R03 R04

   property p_core_top;
      @(posedge clock) disable iff (!rst_n) act.core_buck_code == 6'h3f |=> rail_mv.core_buck == 12'd1800;
   endproperty
   a_core_top: assert property (p_core_top) else $error("core buck top code wrong"); // R13

   property p_ao_sat;
      @(posedge clock) disable iff (!rst_n) act.always_on_code > 4'h8 |=> rail_mv.always_on == 12'd1900;
   endproperty
   a_ao_sat: assert property (p_ao_sat) else $error("always-on saturation wrong"); // R05

   property p_sl_off;
      @(posedge clock) disable iff (!rst_n) act.system_linear_code == 5'h00 && act.system_linear_offset
         |=> rail_mv.system_linear == 12'd2700;
   endproperty
   a_sl_off: assert property (p_sl_off) else $error("system linear offset wrong"); // R08 R09

   property p_ship;
      @(posedge clock) disable iff (!rst_n) act.ship |=> ship_mode;
   endproperty
   a_ship: assert property (p_ship) else $error("ship mode not entered"); // R10

   property p_reg_sel;
      @(posedge clock) disable iff (!rst_n) !act.pin_select && !fall && {mode_reg_bit_b, mode_reg_bit_a} == req_prev_q
         |=> $stable(mode_q);
   endproperty
   a_reg_sel: assert property (p_reg_sel) else $error("pins used while register select"); // R11

   property p_pin_sel;
      @(posedge clock) disable iff (!rst_n) act.pin_select && !fall && req != req_prev_q |=> mode_q == $past(sync2_q[1:0]);
   endproperty
   a_pin_sel: assert property (p_pin_sel) else $error("pins ignored while pin select"); // R12

   property p_wd_flag;
      @(posedge clock) disable iff (!rst_n) fire_d |=> sys_reset ##1 watchdog_reset_flag;
   endproperty
   a_wd_flag: assert property (p_wd_flag) else $error("watchdog expiry not flagged"); // R14

   property p_wd_off;
      @(posedge clock) disable iff (!rst_n) act.watchdog_period == 2'h0 |=> wd_cnt_q == 32'h0000_0000 && !sys_reset;
   endproperty
   a_wd_off: assert property (p_wd_off) else $error("watchdog ran while off"); // R07

   property p_mode2_copy;
      @(posedge clock) disable iff (!rst_n) mode_q == 2'h2 |=> active_cfg == $past(cfg2);
   endproperty
   a_mode2_copy: assert property (p_mode2_copy) else $error("wrong copy drives outputs"); // R15 R06

   property p_write;
      @(posedge clock) disable iff (!rst_n) reg_wr && reg_addr == 8'h2d |=> bank_q[6] == $past(reg_wdata);
   endproperty
   a_write: assert property (p_write) else $error("bank write lost"); // R16

   c_btn_return: cover property (@(posedge clock) disable iff (!rst_n) mode_q != 2'h0 ##1 mode_q == 2'h0 && $past(fall));
   c_wd_fire:    cover property (@(posedge clock) disable iff (!rst_n) sys_reset);
   c_mode2:      cover property (@(posedge clock) disable iff (!rst_n) mode_q == 2'h2 && act.pin_select);
endmodule // mscb_bank

// ---- verif/tb_top.sv ----
// Purpose: Self-checking bench for the mode 1 and mode 2 settings bank
// Assumes: Watchdog base count shortened to 4 cycles for run time
// Notes:   Bench keeps its own copy of the seven bank bytes
`timescale 1ns/1ps
module tb_top;
   localparam longint   WDC = 4;
   logic                clock, rst_n, reg_wr, reg_rd, pin_a, pin_b, bit_a, bit_b, button, kick;
   logic [7:0]          reg_addr, reg_wdata, reg_rdata, part0;
   logic [1:0]          active_mode;
   logic                ship_mode, sys_reset, watchdog_reset_flag;
   mscb_pkg::mscb_cfg_t outer_cfg, active_cfg;
   mscb_pkg::mscb_mv_t  rail_mv;
   logic [7:0]          bank [7];
   logic [31:0]         lfsr_q;
   int                  miscompares, total_checks;

   mscb_bank #(.WD_CYCLES(WDC)) mscb_bank_i (
      .clock(clock), .rst_n(rst_n), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .mode1_part0(part0), .outer_cfg(outer_cfg),
      .mode_pin_a(pin_a), .mode_pin_b(pin_b), .mode_reg_bit_a(bit_a), .mode_reg_bit_b(bit_b),
      .power_button(button), .wd_kick(kick), .active_mode(active_mode), .active_cfg(active_cfg),
      .rail_mv(rail_mv), .ship_mode(ship_mode), .sys_reset(sys_reset),
      .watchdog_reset_flag(watchdog_reset_flag));

   initial begin
      clock = 1'b0;
      forever #50 clock = ~clock;
   end

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   function automatic logic [11:0] coremv(input logic [5:0] c);
      return (c == 6'h3f) ? 12'h708 : (c > 6'h28) ? 12'h5dc : 12'h1f4 + 12'h019 * c;
   endfunction

   function automatic logic [11:0] sysmv(input logic [4:0] c, input logic o);
      return ((c > 5'h18) ? 12'h834 : 12'h5dc + 12'h019 * c) + (o ? 12'h4b0 : 12'h000);
   endfunction

   function automatic logic [11:0] aomv(input logic [3:0] c);
      return (c > 4'h8) ? 12'h76c : 12'h6a4 + 12'h019 * c;
   endfunction

   task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string what);
      total_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clock);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge clock);
      reg_wr <= 1'b0;
      if (a >= 8'h27 && a <= 8'h2d) bank[a - 8'h27] = d;
   endtask

   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(posedge clock);
      reg_rd   <= 1'b1;
      reg_addr <= a;
      @(posedge clock);
      reg_rd <= 1'b0;
      @(negedge clock);
      chk(reg_rdata, exp, "read");
   endtask

   // Waits for the mode, then checks mode, config, rail and ship outputs against the bench copy
   task automatic chk_cfg(input logic [1:0] m);
      logic [31:0] w;
      int          n;
      n = 0;
      while (active_mode !== m && n < 20) begin
         @(negedge clock);
         n++;
      end
      repeat (2) @(negedge clock);
      w = (m == 2'h1) ? {part0, bank[0], bank[1], bank[2]} :
          (m == 2'h2) ? {bank[3], bank[4], bank[5], bank[6]} : outer_cfg;
      chk(active_mode, m, "mode");
      chk(active_cfg, w, "cfg");
      chk(rail_mv, {coremv(w[29:24]), sysmv(w[20:16], w[21]), aomv(w[15:12]), sysmv(w[4:0], w[5])}, "rails");
      chk(ship_mode, w[31], "ship");
   endtask

   task automatic press();
      @(posedge clock);
      button <= 1'b0;
      repeat (6) @(posedge clock);
      button <= 1'b1;
      repeat (6) @(negedge clock);
   endtask

   // Interval between two expiry pulses, bounded so a dead counter cannot hang
   task automatic wd_gap(output int n);
      n = 0;
      // A pulse from the old period would stretch the first gap
      repeat (2) @(negedge clock);
      while (sys_reset !== 1'b1 && n < 200) begin
         @(negedge clock);
         n++;
      end
      n = 0;
      do begin
         @(negedge clock);
         n++;
      end while (sys_reset !== 1'b1 && n < 200);
   endtask

   task automatic test_done();
      $display("checks %0d miscompares %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   initial begin
      #1_000_000;
      miscompares++;
      test_done();
   end

   initial begin
      int n;
      miscompares = 0;
      total_checks = 0;
      lfsr_q = 32'h0001_3754;
      {rst_n, reg_wr, reg_rd, pin_a, pin_b, bit_a, bit_b, kick} = 8'h00;
      {reg_addr, reg_wdata} = 16'h0000;
      button = 1'b1;
      part0 = 8'h1c;
      outer_cfg = 32'h0000_0000;
      bank = '{8'h4c, 8'h4f, 8'h0c, 8'h1c, 8'h4c, 8'h4f, 8'h0c};
      repeat (3) @(posedge clock);
      rst_n <= 1'b1;
      for (int i = 0; i < 7; i++) rd(8'(8'h27 + i), bank[i]);
      rd(8'h30, 8'h00);
      rd(8'h71, 8'h00);
      $display("defaults test done");
      for (int i = 0; i < 8; i++) begin
         lfsr_q = lfsr(lfsr_q);
         wr(8'(8'h27 + i), lfsr_q[7:0]);
      end
      for (int i = 0; i < 7; i++) rd(8'(8'h27 + i), bank[i]);
      rd(8'h2e, 8'h00);
      lfsr_q = lfsr(lfsr_q);
      @(posedge clock);
      outer_cfg <= lfsr_q & 32'hbfff_ffff;
      chk_cfg(2'h0);
      $display("access test done");
      wr(8'h2a, bank[3] & 8'hbf);
      lfsr_q = lfsr(lfsr_q);
      @(posedge clock);
      part0 <= lfsr_q[7:0] & 8'hbf;
      bit_b <= 1'b1;
      chk_cfg(2'h2);
      @(posedge clock);
      pin_a <= 1'b1;
      repeat (6) @(negedge clock);
      chk_cfg(2'h2);
      @(posedge clock);
      {bit_b, bit_a} <= 2'h1;
      chk_cfg(2'h1);
      @(posedge clock);
      part0 <= part0 | 8'h40;
      wr(8'h2a, bank[3] | 8'h40);
      @(posedge clock);
      {pin_b, pin_a} <= 2'h2;
      chk_cfg(2'h2);
      @(posedge clock);
      {bit_b, bit_a} <= 2'h3;
      repeat (6) @(negedge clock);
      chk_cfg(2'h2);
      $display("mode select test done");
      @(posedge clock);
      {bit_b, bit_a} <= 2'h2;
      wr(8'h2b, bank[4] | 8'h40);
      press();
      chk_cfg(2'h2);
      wr(8'h2b, bank[4] & 8'hbf);
      press();
      chk_cfg(2'h0);
      $display("button test done");
      @(posedge clock);
      part0 <= part0 & 8'hbf;
      {bit_b, bit_a} <= 2'h1;
      chk_cfg(2'h1);
      wr(8'h29, bank[2] & 8'h3f);
      wr(8'h71, 8'h02);
      @(negedge clock);
      chk(watchdog_reset_flag, 1'b0, "flag clear before expiry");
      for (int p = 1; p < 4; p++) begin
         wr(8'h29, {2'(p), bank[2][5:0]});
         wd_gap(n);
         chk(n, WDC << (p - 1), "watchdog gap");
         @(negedge clock);
         chk(watchdog_reset_flag, 1'b1, "flag set");
         rd(8'h29, bank[2]);
      end
      // Kicks held on must keep the 64 s period from expiring
      @(posedge clock);
      kick <= 1'b1;
      repeat (2) @(negedge clock);
      repeat (40) begin
         @(negedge clock);
         chk(sys_reset, 1'b0, "kicked watchdog");
      end
      @(posedge clock);
      kick <= 1'b0;
      wr(8'h29, bank[2] & 8'h3f);
      wr(8'h71, 8'h02);
      @(negedge clock);
      chk(watchdog_reset_flag, 1'b0, "flag clear");
      chk_cfg(2'h1);
      @(posedge clock);
      {bit_b, bit_a} <= 2'h3;
      chk_cfg(2'h3);
      $display("watchdog test done");
      test_done();
   end
endmodule // tb_top
